// >>> hdl/irq_group_scan.sv
// Priority encoder for one sweep over all interrupt groups
`timescale 1ns/10ps
`default_nettype none
module irq_group_scan
(
  input wire logic [irq_scan_pkg::NUM_GROUPS*irq_scan_pkg::LINES_PER_GROUP-1:0] eligible,
  output logic hit,
  output logic [irq_scan_pkg::GRP_W-1:0] hit_group,
  output logic [irq_scan_pkg::LVL_W-1:0] hit_level
);
  // Top group and level first, down to group 0 level 0; the last found wins
  always_comb
  begin
    hit = 1'b0;
    hit_group = '0;
    hit_level = '0;
    for (int g = irq_scan_pkg::NUM_GROUPS - 1; g >= 0; g--)
    begin
      for (int l = irq_scan_pkg::LINES_PER_GROUP - 1; l >= 0; l--)
      begin
        if (eligible[g*irq_scan_pkg::LINES_PER_GROUP+l])
        begin
          hit = 1'b1;
          hit_group = irq_scan_pkg::GRP_W'(g);
          hit_level = irq_scan_pkg::LVL_W'(l);
        end
      end
    end
  end
endmodule : irq_group_scan
`default_nettype wire

// >>> hdl/irq_scan_pkg.sv
// Shared constants for the priority interrupt scanner
package irq_scan_pkg;
  localparam int LINES_PER_GROUP = 16;
  localparam int EXT_GROUPS = 16;
  localparam int NUM_GROUPS = 17;
  localparam int GRP_W = 5;
  localparam int LVL_W = 4;
  localparam int VEC_W = 9;
  localparam int ADDR_W = 16;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  // Internal line numbers
  localparam logic [3:0] LINE_POWER = 4'h0;
  localparam logic [3:0] LINE_PARITY = 4'h1;
  localparam logic [3:0] LINE_TAG = 4'h3;
  localparam logic [3:0] LINE_EXPONENT = 4'h4;
  localparam logic [3:0] LINE_PROTECT = 4'h5;
  localparam logic [3:0] LINE_TIMER = 4'h6;
  localparam logic [3:0] LINE_CONSOLE = 4'h7;
  localparam logic [3:0] LINE_CHAN0 = 4'h8;
  localparam logic [3:0] LINE_CHAN_SHARED = 4'hC;
  // Vector table base address, arbitrary plain default
  localparam logic [15:0] VECTOR_BASE = 16'h0100;
  localparam logic [15:0] MASK_RESET = 16'hFFFF;
  localparam logic [15:0] GROUP_EN_RESET = 16'hFFFF;
  localparam logic [GRP_W-1:0] GROUP_NONE = 5'h1F;
  localparam logic [LVL_W-1:0] LEVEL_IDLE = 4'hF;
  // Vector instruction kinds
  typedef enum logic [1:0] {VEC_LINK, VEC_EXECUTE, VEC_OTHER} vec_kind_t;
  // Tag interrupt capture points
  typedef enum logic [1:0] {TAG_NONE, TAG_FETCH, TAG_INDIRECT, TAG_OPERAND} tag_point_t;
endpackage : irq_scan_pkg

// >>> hdl/priority_interrupt_scanner.sv
// Priority interrupt scanner with masks, vectoring and status lines
//
// Contract
// - Lines 3-7: tag, exponent, protect, timer, console
// - Lines 8-15 channels; last four external optional
// - Sixteen-line groups: internal, then external 0-255
// - Earlier group and lower level win
// - Sweep from group 0 each instruction cycle
// - Only higher priority preempts running service
// - Break only between instruction end and fetch
// - Fetch tag or parity taken before execution
// - Global enable flag gates all levels but power failure
// - Power failure ignores enable, never disabled
// - Internal and external masks gate groups 0,1
// - Groups above one inhibited by function lines
// - Each line vectors to its own location
// - Vector instruction runs uninterrupted
// - Link vector stores counter, starts next cell
// - Execute vector keeps counter unless jump
// - Other vector executes then resumes counter
// - Four status/function banks, two internal
// - Test copies to zero; conflict sets busy
// - Bank 0 processor lines, bank 1 channels
// - Tag test sets zero when tag high
// - Tag interrupt at three cycle points
// - Line 0 power failure, line 1 parity
`timescale 1ns/10ps
`default_nettype none
module priority_interrupt_scanner
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Instruction cycle points from the core
  input wire logic cycle_start,
  input wire logic instr_done,
  input wire logic fetch_done,
  input wire logic indirect_done,
  input wire logic service_return,
  // Internal condition sources and external interrupt lines
  input wire logic power_fail,
  input wire logic parity_error,
  input wire logic tag_read,
  input wire logic exponent_fault,
  input wire logic protect_violation,
  input wire logic timer_zero,
  input wire logic [3:0] console_button,
  input wire logic [7:0] channel_irq,
  input wire logic channels_5_8_installed,
  input wire logic [255:0] ext_irq,
  // Flag and mask instructions
  input wire logic load_flag_instruction,
  input wire logic flag_test_set_jump_instruction,
  input wire logic flag_test_reset_jump_instruction,
  input wire logic flag_enable_value,
  input wire logic load_internal_mask_instruction,
  input wire logic load_external_mask_instruction,
  input wire logic [15:0] mask_data,
  // Status/function line instruction
  input wire logic status_function_line_instruction,
  input wire logic sfl_set,
  input wire logic sfl_reset,
  input wire logic [1:0] sfl_bank,
  input wire logic [15:0] sfl_lines,
  input wire logic [15:0] status_bank0,
  input wire logic [15:0] status_bank1,
  input wire logic [15:0] status_bank2,
  input wire logic [15:0] status_bank3,
  input wire logic [15:0] conflict_bank,
  // Tag bit test and vector instruction decode
  input wire logic tag_test,
  input wire logic tag_bit,
  input wire logic vector_done,
  input wire logic [1:0] vector_kind,
  input wire logic vector_target_jump,
  input wire logic [15:0] vector_link_addr,
  input wire logic [15:0] location_counter,
  // Outputs to the core
  output logic take_interrupt,
  output logic [15:0] vector_addr,
  output logic in_vector,
  output logic store_lc,
  output logic [15:0] store_addr,
  output logic [15:0] store_data,
  output logic load_lc,
  output logic [15:0] lc_value,
  output logic [2:0] tag_point,
  output logic enable_flag,
  output logic zero_flag,
  output logic busy_flag,
  output logic [15:0] func_bank0,
  output logic [15:0] func_bank1,
  output logic [15:0] func_bank2,
  output logic [15:0] func_bank3,
  output logic [4:0] active_group,
  output logic [3:0] active_level
);
  localparam int NL = irq_scan_pkg::NUM_GROUPS * irq_scan_pkg::LINES_PER_GROUP;

  logic [15:0] int_mask_q;
  logic [15:0] ext_mask_q;
  logic enable_q;
  logic [NL-1:0] pend_q;
  logic [NL-1:0] raw;
  logic [NL-1:0] eligible;
  logic [15:0] internal_lines;
  logic [15:0] group_on;
  logic hit;
  logic [4:0] hit_group;
  logic [3:0] hit_level;
  logic hit_q;
  logic [4:0] hit_group_q;
  logic [3:0] hit_level_q;
  logic [4:0] act_group_q;
  logic [3:0] act_level_q;
  logic take_q;
  logic in_vector_q;
  logic fetch_fault;
  logic [4:0] sel_group;
  logic [3:0] sel_level;
  logic sfl_zero;
  logic sfl_busy;

  // Flat line index of a group and level
  function automatic logic [8:0] line_index(input logic [4:0] g, input logic [3:0] l);
    line_index = {g, 4'h0} + {5'h00, l};
  endfunction : line_index

  // True when a line outranks the one in service
  function automatic logic outranks(input logic [4:0] g, input logic [3:0] l,
                                    input logic [4:0] ag, input logic [3:0] al);
    outranks = (g < ag) || ((g == ag) && (l < al));
  endfunction : outranks

  // Internal condition lines; line 2 stays reserved
  always_comb
  begin
    internal_lines = 16'h0000;
    internal_lines[irq_scan_pkg::LINE_POWER] = power_fail;
    internal_lines[irq_scan_pkg::LINE_PARITY] = parity_error;
    internal_lines[irq_scan_pkg::LINE_TAG] = tag_read;
    internal_lines[irq_scan_pkg::LINE_EXPONENT] = exponent_fault;
    internal_lines[irq_scan_pkg::LINE_PROTECT] = protect_violation;
    internal_lines[irq_scan_pkg::LINE_TIMER] = timer_zero;
    internal_lines[irq_scan_pkg::LINE_CONSOLE] = |console_button;
    internal_lines[15:8] = channel_irq;
    // Shared lines take external sources when channels 5-8 are absent
    if (!channels_5_8_installed)
      internal_lines[15:12] = ext_irq[3:0];
  end

  // Function bank 2 bit g-2 inhibits external group g; group 1 uses its mask
  assign group_on = ~func_bank2;

  assign raw = {ext_irq, internal_lines};

  // Eligibility: enable, masks, group inhibit, service priority
  always_comb
  begin
    eligible = '0;
    for (int g = 0; g < irq_scan_pkg::NUM_GROUPS; g++)
    begin
      for (int l = 0; l < irq_scan_pkg::LINES_PER_GROUP; l++)
      begin
        if (pend_q[g*16+l] && !in_vector_q)
        begin
          if (g == 0)
            eligible[l] = int_mask_q[l] && (enable_q || l == 0);
          else if (g == 1)
            eligible[16+l] = ext_mask_q[l] && enable_q;
          else
            eligible[g*16+l] = group_on[g-2] && enable_q;
          if (!outranks(5'(g), 4'(l), act_group_q, act_level_q))
            eligible[g*16+l] = 1'b0;
        end
      end
    end
    // Power failure cannot be masked or disabled
    if (pend_q[0] && !in_vector_q)
      eligible[0] = outranks(5'h00, 4'h0, act_group_q, act_level_q);
  end

  irq_group_scan u_scan
  (
    .eligible(eligible),
    .hit(hit),
    .hit_group(hit_group),
    .hit_level(hit_level)
  );

  // Pending lines latch until taken; a new edge beats the clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pend_q <= '0;
    else if (ce)
    begin
      if (take_d())
        pend_q <= (pend_q & ~(NL'(1) << line_index(sel_group, sel_level))) | raw;
      else
        pend_q <= pend_q | raw;
    end
  end

  // Fetch time tag or parity fault breaks before execution
  assign fetch_fault = fetch_done && (tag_read || parity_error);

  // A faulted fetch breaks on the live sweep, since no latched one exists yet
  function automatic logic take_d();
    take_d = (fetch_fault ? hit : (hit_q && instr_done)) && !take_q;
  endfunction : take_d
  assign sel_group = fetch_fault ? hit_group : hit_group_q;
  assign sel_level = fetch_fault ? hit_level : hit_level_q;

  // Sweep result captured at each instruction cycle start
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hit_q <= 1'b0;
      hit_group_q <= '0;
      hit_level_q <= '0;
    end
    else if (ce)
    begin
      if (cycle_start || fetch_fault)
      begin
        hit_q <= hit;
        hit_group_q <= hit_group;
        hit_level_q <= hit_level;
      end
      else if (take_q)
        hit_q <= 1'b0;
    end
  end

  // Take strobe, vector address and service level
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      take_q <= 1'b0;
      vector_addr <= 16'h0000;
      in_vector_q <= 1'b0;
      act_group_q <= irq_scan_pkg::GROUP_NONE;
      act_level_q <= irq_scan_pkg::LEVEL_IDLE;
    end
    else if (ce)
    begin
      take_q <= take_d();
      if (take_d())
      begin
        vector_addr <= irq_scan_pkg::VECTOR_BASE + {7'h00, line_index(sel_group, sel_level)};
        in_vector_q <= 1'b1;
        act_group_q <= sel_group;
        act_level_q <= sel_level;
      end
      else if (vector_done)
        in_vector_q <= 1'b0;
      else if (service_return)
      begin
        act_group_q <= irq_scan_pkg::GROUP_NONE;
        act_level_q <= irq_scan_pkg::LEVEL_IDLE;
      end
    end
  end

  // Vector instruction outcome on the location counter
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      store_lc <= 1'b0;
      store_addr <= 16'h0000;
      store_data <= 16'h0000;
      load_lc <= 1'b0;
      lc_value <= 16'h0000;
    end
    else if (ce)
    begin
      store_lc <= 1'b0;
      load_lc <= 1'b0;
      if (in_vector_q && vector_done)
      begin
        case (irq_scan_pkg::vec_kind_t'(vector_kind))
          irq_scan_pkg::VEC_LINK:
          begin
            store_lc <= 1'b1;
            store_addr <= vector_link_addr;
            store_data <= location_counter;
            load_lc <= 1'b1;
            lc_value <= vector_link_addr + 16'h0001;
          end
          irq_scan_pkg::VEC_EXECUTE:
          begin
            load_lc <= !vector_target_jump ? 1'b1 : 1'b0;
            lc_value <= location_counter;
          end
          irq_scan_pkg::VEC_OTHER:
          begin
            load_lc <= 1'b1;
            lc_value <= location_counter;
          end
          default:
          begin
            load_lc <= 1'b1;
            lc_value <= location_counter;
          end
        endcase
      end
    end
  end

  // Masks and global enable
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      int_mask_q <= irq_scan_pkg::MASK_RESET;
      ext_mask_q <= irq_scan_pkg::MASK_RESET;
      enable_q <= 1'b0;
    end
    else if (ce)
    begin
      if (load_internal_mask_instruction)
        int_mask_q <= mask_data;
      if (load_external_mask_instruction)
        ext_mask_q <= mask_data;
      if (load_flag_instruction)
        enable_q <= flag_enable_value;
      else if (flag_test_set_jump_instruction)
        enable_q <= 1'b1;
      else if (flag_test_reset_jump_instruction)
        enable_q <= 1'b0;
    end
  end

  // Tag capture point of the current read
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      tag_point <= 3'h0;
    else if (ce)
      tag_point <= {tag_read && instr_done, tag_read && indirect_done, tag_read && fetch_done};
  end

  status_line_banks u_banks
  (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .sfl_valid(status_function_line_instruction),
    .sfl_set(sfl_set),
    .sfl_reset(sfl_reset),
    .sfl_bank(sfl_bank),
    .sfl_lines(sfl_lines),
    .status_bank0(status_bank0),
    .status_bank1(status_bank1),
    .status_bank2(status_bank2),
    .status_bank3(status_bank3),
    .conflict_bank(conflict_bank),
    .func_bank0(func_bank0),
    .func_bank1(func_bank1),
    .func_bank2(func_bank2),
    .func_bank3(func_bank3),
    .test_zero(sfl_zero),
    .set_busy(sfl_busy)
  );

  // Zero flag from line test or tag test; bank 0/1 meaning lies with the core
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      zero_flag <= 1'b0;
      busy_flag <= 1'b0;
    end
    else if (ce)
    begin
      if (tag_test)
        zero_flag <= tag_bit;
      else if (status_function_line_instruction)
        zero_flag <= (sfl_lines & (sfl_bank == 2'h0 ? status_bank0 : sfl_bank == 2'h1 ? status_bank1 :
                      sfl_bank == 2'h2 ? status_bank2 : status_bank3)) != 16'h0000;
      if (status_function_line_instruction)
        busy_flag <= sfl_set && ((sfl_lines & conflict_bank) != 16'h0000);
    end
  end

  assign take_interrupt = take_q;
  assign in_vector = in_vector_q;
  assign enable_flag = enable_q;
  assign active_group = act_group_q;
  assign active_level = act_level_q;
endmodule : priority_interrupt_scanner
`default_nettype wire

// >>> hdl/status_line_banks.sv
// Four banks of program testable status and settable function lines
`timescale 1ns/10ps
`default_nettype none
module status_line_banks
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic sfl_valid,
  input wire logic sfl_set,
  input wire logic sfl_reset,
  input wire logic [irq_scan_pkg::BANK_W-1:0] sfl_bank,
  input wire logic [15:0] sfl_lines,
  input wire logic [15:0] status_bank0,
  input wire logic [15:0] status_bank1,
  input wire logic [15:0] status_bank2,
  input wire logic [15:0] status_bank3,
  input wire logic [15:0] conflict_bank,
  output logic [15:0] func_bank0,
  output logic [15:0] func_bank1,
  output logic [15:0] func_bank2,
  output logic [15:0] func_bank3,
  output logic test_zero,
  output logic set_busy
);
  logic [15:0] func_q [irq_scan_pkg::NUM_BANKS];
  logic [15:0] stat_sel;
  logic blocked;

  // Selected bank's status lines
  always_comb
  begin
    case (sfl_bank)
      2'h0: stat_sel = status_bank0;
      2'h1: stat_sel = status_bank1;
      2'h2: stat_sel = status_bank2;
      default: stat_sel = status_bank3;
    endcase
  end

  assign blocked = sfl_set && ((sfl_lines & conflict_bank) != 16'h0000);

  // Function line store; a conflicting set is refused whole
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int b = 0; b < irq_scan_pkg::NUM_BANKS; b++)
        func_q[b] <= 16'h0000;
    end
    else if (ce && sfl_valid)
    begin
      if (sfl_set && !blocked)
        func_q[sfl_bank] <= func_q[sfl_bank] | sfl_lines;
      else if (sfl_reset)
        func_q[sfl_bank] <= func_q[sfl_bank] & ~sfl_lines;
    end
  end

  // Zero flag follows tested lines, busy flags a refused set
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      test_zero <= 1'b0;
      set_busy <= 1'b0;
    end
    else if (ce && sfl_valid)
    begin
      test_zero <= ((stat_sel & sfl_lines) != 16'h0000);
      set_busy <= blocked;
    end
  end

  assign func_bank0 = func_q[0];
  assign func_bank1 = func_q[1];
  assign func_bank2 = func_q[2];
  assign func_bank3 = func_q[3];
endmodule : status_line_banks
`default_nettype wire

// >>> verif/core_model.sv
// Processor core stand-in that sequences instruction cycles
`timescale 1ns/10ps
`default_nettype none
module core_model
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic slow,
  input wire logic take_interrupt,
  output logic cycle_start,
  output logic instr_done,
  output logic vector_done
);
  logic [2:0] lag_q;
  // Cycle timing
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {cycle_start, instr_done, vector_done, lag_q} <= '0;
    end
    else
    begin
      cycle_start <= go;
      instr_done <= cycle_start;
      lag_q <= {lag_q[1:0], take_interrupt};
      // Slow: vector ends late
      vector_done <= slow ? lag_q[2] : take_interrupt;
    end
  end
endmodule : core_model
`default_nettype wire

// >>> verif/irq_scan_monitor.sv
// Concurrent checks on the interrupt scanner ports
`timescale 1ns/10ps
`default_nettype none
module irq_scan_monitor
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic instr_done,
  input wire logic fetch_done,
  input wire logic service_return,
  input wire logic tag_test,
  input wire logic tag_bit,
  input wire logic load_flag_instruction,
  input wire logic flag_test_reset_jump_instruction,
  input wire logic flag_enable_value,
  input wire logic vector_done,
  input wire logic [1:0] vector_kind,
  input wire logic [15:0] vector_link_addr,
  input wire logic [15:0] location_counter,
  input wire logic take_interrupt,
  input wire logic [15:0] vector_addr,
  input wire logic in_vector,
  input wire logic store_lc,
  input wire logic [15:0] store_data,
  input wire logic load_lc,
  input wire logic [15:0] lc_value,
  input wire logic enable_flag,
  input wire logic zero_flag,
  input wire logic [4:0] active_group,
  input wire logic [3:0] active_level
);
  // One clock domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_take_cause; take_interrupt |-> $past(instr_done) || $past(fetch_done); endproperty
  a_take_cause: assert property (p_take_cause) else $error("take off boundary");
  property p_no_nest; in_vector && !$rose(in_vector) |-> !take_interrupt; endproperty
  a_no_nest: assert property (p_no_nest) else $error("nested take");
  property p_vec_addr; take_interrupt && !service_return |=> vector_addr == 16'h0100 + {7'h00, active_group, active_level}; endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address");
  property p_vec_exit; vector_done && in_vector |=> !in_vector; endproperty
  a_vec_exit: assert property (p_vec_exit) else $error("vector open");
  property p_link; vector_done && in_vector && vector_kind == 2'h0 |=> store_lc && load_lc &&
    store_data == $past(location_counter) && lc_value == $past(vector_link_addr) + 16'h0001; endproperty
  a_link: assert property (p_link) else $error("link vector");
  property p_other; vector_done && in_vector && vector_kind == 2'h2 |=> load_lc && !store_lc && lc_value == $past(location_counter); endproperty
  a_other: assert property (p_other) else $error("other vector");
  property p_tag_zero; tag_test |=> zero_flag == $past(tag_bit); endproperty
  a_tag_zero: assert property (p_tag_zero) else $error("tag zero");
  property p_load_flag; load_flag_instruction |=> enable_flag == $past(flag_enable_value); endproperty
  a_load_flag: assert property (p_load_flag) else $error("enable load");
  property p_clear_flag; flag_test_reset_jump_instruction && !load_flag_instruction |=> !enable_flag; endproperty
  a_clear_flag: assert property (p_clear_flag) else $error("enable clear");
  // Scenarios
  c_take: cover property (take_interrupt);
  c_fetch: cover property (fetch_done ##1 take_interrupt);
  c_link: cover property (vector_done && in_vector && vector_kind == 2'h0);
endmodule : irq_scan_monitor
bind priority_interrupt_scanner irq_scan_monitor monitor (.clk, .nrst, .instr_done, .fetch_done, .service_return,
  .tag_test, .tag_bit, .load_flag_instruction, .flag_test_reset_jump_instruction, .flag_enable_value, .vector_done,
  .vector_kind, .vector_link_addr, .location_counter, .take_interrupt, .vector_addr, .in_vector, .store_lc,
  .store_data, .load_lc, .lc_value, .enable_flag, .zero_flag, .active_group, .active_level);
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the priority interrupt scanner
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk, nrst, ce, go, slow, cycle_start, instr_done, fetch_done, indirect_done, flag_enable_value;
  logic power_fail, parity_error, tag_read, exponent_fault, protect_violation, timer_zero, channels_5_8_installed;
  logic [3:0] console_button;
  logic [7:0] channel_irq;
  logic [255:0] ext_irq;
  logic [7:0] ops;
  logic sfl_set, sfl_reset, tag_bit, vector_done, vector_target_jump, took, st, tp;
  logic [1:0] sfl_bank, vector_kind;
  logic [15:0] mask_data, sfl_lines, stat, conflict_bank, vector_link_addr, location_counter, sa, sd, lv;
  logic take_interrupt, in_vector, store_lc, load_lc, enable_flag, zero_flag, busy_flag;
  logic [15:0] vector_addr, store_addr, store_data, lc_value, func_bank0, func_bank1, func_bank2, func_bank3;
  logic [2:0] tag_point;
  logic [4:0] active_group;
  logic [3:0] active_level;
  int error_cnt, check_count, k;
  int lines_tbl[8] = '{1, 3, 5, 6, 7, 8, 15, 271};

  always #2 clk = ~clk;

  priority_interrupt_scanner dut (.clk, .nrst, .ce, .cycle_start, .instr_done, .fetch_done, .indirect_done,
    .service_return(ops[5]), .power_fail, .parity_error, .tag_read, .exponent_fault, .protect_violation,
    .timer_zero, .console_button, .channel_irq, .channels_5_8_installed, .ext_irq, .load_flag_instruction(ops[0]),
    .flag_test_set_jump_instruction(ops[1]), .flag_test_reset_jump_instruction(ops[2]), .flag_enable_value,
    .load_internal_mask_instruction(ops[3]), .load_external_mask_instruction(ops[4]), .mask_data,
    .status_function_line_instruction(ops[7]), .sfl_set, .sfl_reset, .sfl_bank, .sfl_lines, .status_bank0(stat),
    .status_bank1(stat), .status_bank2(stat), .status_bank3(stat), .conflict_bank, .tag_test(ops[6]), .tag_bit,
    .vector_done, .vector_kind, .vector_target_jump,
    .vector_link_addr, .location_counter, .take_interrupt, .vector_addr, .in_vector, .store_lc, .store_addr,
    .store_data, .load_lc, .lc_value, .tag_point, .enable_flag, .zero_flag, .busy_flag, .func_bank0, .func_bank1,
    .func_bank2, .func_bank3, .active_group, .active_level);
  core_model core (.clk, .nrst, .go, .slow, .take_interrupt, .cycle_start, .instr_done, .vector_done);

  task automatic tk;
    @(posedge clk);
  endtask : tk
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chkb(string nm, logic e, logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask : chkb
  // Instruction strobe, then let it land
  task automatic op(int w);
    ops[w] <= 1'b1;
    tk;
    ops <= 8'h00;
    tk;
  endtask : op
  // One-cycle line pulse; pending must hold it
  task automatic src(int ln);
    case (ln)
      0: power_fail <= 1'b1;
      1: parity_error <= 1'b1;
      3: tag_read <= 1'b1;
      4: exponent_fault <= 1'b1;
      5: protect_violation <= 1'b1;
      6: timer_zero <= 1'b1;
      7: console_button <= 4'h4;
      default: if (ln < 16) channel_irq[ln-8] <= 1'b1; else ext_irq[ln-16] <= 1'b1;
    endcase
    tk;
    {power_fail, parity_error, tag_read, exponent_fault, protect_violation, timer_zero} <= 6'h00;
    {console_button, channel_irq, ext_irq} <= '0;
  endtask : src
  // One instruction cycle
  task automatic run(string nm, logic et, int ln);
    took = 1'b0;
    {st, sa, sd, lv} = '0;
    go <= 1'b1;
    tk;
    go <= 1'b0;
    repeat (11)
    begin
      tk;
      if (take_interrupt === 1'b1) took = 1'b1;
      if (store_lc === 1'b1) {st, sa, sd} = {1'b1, store_addr, store_data};
      if (load_lc === 1'b1) lv = lc_value;
    end
    chkb(nm, et, took);
    if (et) chk(nm, 16'h0100 + 16'(ln), vector_addr);
  endtask : run
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  initial
  begin
    {clk, nrst, go, slow, fetch_done, indirect_done, ops, power_fail, parity_error, tag_read} = '0;
    {exponent_fault, protect_violation, timer_zero, console_button, channel_irq, ext_irq, flag_enable_value} = '0;
    {sfl_set, sfl_reset, sfl_bank, sfl_lines, stat, conflict_bank, mask_data, tag_bit, vector_target_jump} = '0;
    {ce, channels_5_8_installed, vector_kind, vector_link_addr, location_counter} = {2'h3, 2'h2, 32'h2000_1234};
    repeat (3) tk;
    nrst <= 1'b1;
    tk;
    chkb("enable_rst", 1'b0, enable_flag);
    chk("group_rst", 16'h001F, {11'h000, active_group});
    $display("test reset done");
    src(4);
    run("disabled", 1'b0, 4);
    src(0);
    run("power", 1'b1, 0);
    op(5);
    flag_enable_value <= 1'b1;
    op(0);
    chkb("load_flag", 1'b1, enable_flag);
    run("pending", 1'b1, 4);
    op(5);
    op(2);
    chkb("clear_flag", 1'b0, enable_flag);
    op(1);
    chkb("set_flag", 1'b1, enable_flag);
    $display("test enable done");
    foreach (lines_tbl[i])
    begin
      src(lines_tbl[i]);
      run("line", 1'b1, lines_tbl[i]);
      op(5);
    end
    src(16);
    src(6);
    run("prio", 1'b1, 6);
    run("preempt", 1'b0, 16);
    op(5);
    run("resume", 1'b1, 16);
    op(5);
    $display("test priority done");
    for (k = 0; k < 2; k++)
    begin
      mask_data <= k ? 16'hFFFE : 16'hFFDF;
      op(3 + k);
      src(k ? 16 : 5);
      run("masked", 1'b0, 0);
      mask_data <= 16'hFFFF;
      op(3 + k);
      run("unmasked", 1'b1, k ? 16 : 5);
      op(5);
    end
    {sfl_set, sfl_bank, sfl_lines} <= {1'b1, 2'h2, 16'h0001};
    op(7);
    chk("func2", 16'h0001, func_bank2);
    src(32);
    run("inhibit", 1'b0, 32);
    {sfl_set, sfl_reset} <= 2'h1;
    op(7);
    run("release", 1'b1, 32);
    op(5);
    {sfl_set, sfl_reset, sfl_bank, sfl_lines, conflict_bank} <= {2'h2, 2'h3, 32'h0004_0004};
    op(7);
    chkb("busy", 1'b1, busy_flag);
    chk("func3", 16'h0000, func_bank3);
    {sfl_set, sfl_bank, stat} <= {1'b0, 2'h1, 16'h0004};
    op(7);
    chkb("status", 1'b1, zero_flag);
    $display("test masks and lines done");
    for (k = 0; k < 3; k++)
    begin
      {vector_kind, slow, location_counter} <= {2'(k), k == 1, 16'h1234 + 16'(k)};
      src(6);
      run("kind", 1'b1, 6);
      chkb("store", k == 0, st);
      if (k != 1) chk("resume_at", k == 0 ? 16'h2001 : 16'h1236, lv);
      if (k == 0) chk("stored", 16'h1234, sd);
      if (k == 0) chk("store_at", 16'h2000, sa);
      op(5);
    end
    {vector_kind, slow} <= {2'h2, 1'b0};
    $display("test vectors done");
    tag_read <= 1'b1;
    tk;
    fetch_done <= 1'b1;
    tk;
    {fetch_done, tag_read} <= 2'h0;
    {took, tp} = 2'h0;
    repeat (6)
    begin
      tk;
      if (take_interrupt === 1'b1) took = 1'b1;
      if (tag_point[0] === 1'b1) tp = 1'b1;
    end
    chkb("fetch_take", 1'b1, took);
    chk("fetch_vec", 16'h0103, vector_addr);
    chkb("tag_point", 1'b1, tp);
    op(5);
    tag_bit <= 1'b1;
    op(6);
    chkb("tag_one", 1'b1, zero_flag);
    tag_bit <= 1'b0;
    op(6);
    chkb("tag_zero", 1'b0, zero_flag);
    $display("test tags done");
    conclude;
  end

  // Run is ~370 cycles; cut a hang
  initial
  begin
    repeat (5000) tk;
    error_cnt++;
    conclude;
  end
endmodule : testbench
`default_nettype wire
